// File: src/sbrg_regs.svh
// register indices, field positions, reset values and divide counts of the baud generator
`ifndef SBRG_REGS_SVH
`define SBRG_REGS_SVH

// ====================================================================
// register indices: the byte address is four times the index
`define SBRG_RCS_IDX 10'h018
`define SBRG_TCS_IDX 10'h098
`define SBRG_DIV_IDX 10'h099

// ====================================================================
// transmit_control_status fields
`define SBRG_TCS_CLKSRC 7
`define SBRG_TCS_TX9 6
`define SBRG_TCS_TXEN 5
`define SBRG_TCS_SYNC 4
`define SBRG_TCS_HSS 2
`define SBRG_TCS_SRE 1
`define SBRG_TCS_TX9D 0
`define SBRG_TCS_WMASK 8'hF5

// ====================================================================
// receive_control_status fields
`define SBRG_RCS_PEN 7
`define SBRG_RCS_RX9 6
`define SBRG_RCS_SINGLE 5
`define SBRG_RCS_CONT 4
`define SBRG_RCS_WMASK 8'hF0

// ====================================================================
// reset values
`define SBRG_TCS_RST 8'h02
`define SBRG_RCS_RST 8'h00
`define SBRG_DIV_RST 8'h00

// ====================================================================
// divide counts: prescale by 4, then timer, then per-mode subdivision
`define SBRG_PRE_LAST 2'h3
`define SBRG_LOW_LAST 4'hF
`define SBRG_HIGH_LAST 4'h3
`define SBRG_SYNC_LAST 4'h0
`define SBRG_LOW_VOTE_AT 4'h7
`define SBRG_HIGH_VOTE_AT 4'h1
`define SBRG_LOW_RATIO 16'h0040
`define SBRG_HIGH_RATIO 16'h0010
`define SBRG_SYNC_RATIO 16'h0004

`endif

// File: src/sbrg_pkg.sv
// types shared by the baud generator and its receive sampler
package sbrg_pkg;

	// ====================================================================
	// rate modes
	typedef enum logic [1:0] {
		SBRG_ASYNC_LOW,
		SBRG_ASYNC_HIGH,
		SBRG_SYNC_MASTER,
		SBRG_SYNC_SLAVE
	} sbrg_mode_t;

	// ====================================================================
	// majority sampler states
	typedef enum logic [1:0] {
		SBRG_VOTE_IDLE,
		SBRG_VOTE_SECOND,
		SBRG_VOTE_THIRD
	} sbrg_vote_state_t;

	// ====================================================================
	// control bits handed to the transmitter and receiver
	typedef struct packed {
		logic port_en;
		logic rx9;
		logic single_rx;
		logic cont_rx;
		logic clock_source_select;
		logic tx9;
		logic tx_en;
		logic sync;
		logic high_speed_select;
		logic tx9d;
	} sbrg_ctrl_t;

	// status bits reported back by the receiver
	typedef struct packed {
		logic frame_err;
		logic overrun_err;
		logic rx9d;
	} sbrg_rx_stat_t;

endpackage : sbrg_pkg

// File: src/sbrg_vote.sv
// three-sample majority detector for the receive data pin
`timescale 1ns/1ps
`default_nettype none

module sbrg_vote
	import sbrg_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic start,
	input wire logic strobe,
	input wire logic din,
	output logic vote,
	output logic vote_valid
);

	sbrg_vote_state_t state;
	sbrg_vote_state_t next_state;
	logic first;
	logic second;
	logic majority;

	// ====================================================================
	// vote
	assign majority = (first & second) | (first & din) | (second & din);

	always_comb begin
		next_state = state;
		case (state)
			SBRG_VOTE_IDLE: if (start) next_state = SBRG_VOTE_SECOND;
			SBRG_VOTE_SECOND: if (strobe) next_state = SBRG_VOTE_THIRD;
			SBRG_VOTE_THIRD: if (strobe) next_state = SBRG_VOTE_IDLE;
			default: next_state = SBRG_VOTE_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= SBRG_VOTE_IDLE;
			first <= 1'h0;
			second <= 1'h0;
			vote <= 1'h1;
			vote_valid <= 1'h0;
		end else if (ce) begin
			state <= next_state;
			vote_valid <= 1'h0;
			case (state)
				SBRG_VOTE_IDLE: if (start) first <= din;
				SBRG_VOTE_SECOND: if (strobe) second <= din;
				SBRG_VOTE_THIRD: if (strobe) begin
					vote <= majority;
					vote_valid <= 1'h1;
				end
				default: first <= first;
			endcase
		end
	end

	// ====================================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_vote_begin;
		ce && state == SBRG_VOTE_IDLE && start;
	endsequence

	property p_vote_begin;
		s_vote_begin |=> state == SBRG_VOTE_SECOND && first == $past(din);
	endproperty
	a_vote_begin: assert property (p_vote_begin) else $error("sampler missed first sample");

	property p_vote_agree;
		(ce && state == SBRG_VOTE_THIRD && strobe && first == second)
			|=> vote == $past(first) && vote_valid;
	endproperty
	a_vote_agree: assert property (p_vote_agree) else $error("two agreeing samples outvoted");

	property p_vote_single;
		(vote_valid && ce) |=> !vote_valid;
	endproperty
	a_vote_single: assert property (p_vote_single) else $error("vote valid longer than one cycle");

endmodule : sbrg_vote

`default_nettype wire

// File: src/sbrg_top.sv
// apb-reachable serial baud rate generator with majority-vote receive sampling
`timescale 1ns/1ps
`default_nettype none
`include "sbrg_regs.svh"

// Notes on behaviour
// - a divisor write clears the timer so the new rate starts at once
// - receive pin is sampled three times and the level is decided by majority, except as sync slave
// - async low speed: bit rate is clock over 64 times divisor plus one
// - async high speed: bit rate is clock over 16 times divisor plus one
// - sync mode: bit clock is clock over 4 times divisor plus one
// - divisor is unsigned 8-bit, zero fastest and 255 slowest
// - generator is a free-running 8-bit timer whose period the divisor sets
// - in sync mode the high-speed select has no effect
// - sync formula holds only as clock master; sync slave still gets timer ticks but no bit ticks
module sbrg_top
	import sbrg_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sbrg_rx_stat_t rx_status,
	input wire logic shift_register_empty,
	input wire logic receive_data_pin,
	output sbrg_ctrl_t ctrl,
	output logic timer_tick,
	output logic bit_tick,
	output logic rx_bit,
	output logic rx_bit_valid
);

	// ====================================================================
	// register storage
	logic [7:0] tcs;
	logic [7:0] rcs;
	logic [7:0] baud_divisor;

	// ====================================================================
	// apb decode
	logic hit_rcs;
	logic hit_tcs;
	logic hit_div;
	logic hit_any;
	logic access;
	logic done;
	logic wr_en;
	logic wr_rcs;
	logic wr_tcs;
	logic wr_div;
	logic restart;
	logic [7:0] rd_val;
	logic [7:0] tcs_read;
	logic [7:0] rcs_read;

	assign hit_rcs = paddr == {`SBRG_RCS_IDX, 2'h0};
	assign hit_tcs = paddr == {`SBRG_TCS_IDX, 2'h0};
	assign hit_div = paddr == {`SBRG_DIV_IDX, 2'h0};
	assign hit_any = hit_rcs | hit_tcs | hit_div;
	// first access cycle; the answer comes one cycle later
	assign access = psel & penable & ~pready;
	assign done = psel & penable & pready;
	assign wr_en = done & pwrite & ~pslverr;
	assign wr_rcs = wr_en & hit_rcs;
	assign wr_tcs = wr_en & hit_tcs;
	assign wr_div = wr_en & hit_div;
	// a mode change restarts too, so no bit period mixes two rates
	assign restart = wr_div | wr_tcs;

	assign tcs_read = {tcs[7:3] & 5'h1E, tcs[`SBRG_TCS_HSS], shift_register_empty,
		tcs[`SBRG_TCS_TX9D]};
	assign rcs_read = {rcs[7:4], 1'h0, rx_status.frame_err, rx_status.overrun_err,
		rx_status.rx9d};

	always_comb begin
		if (hit_rcs) begin
			rd_val = rcs_read;
		end else if (hit_tcs) begin
			rd_val = tcs_read;
		end else if (hit_div) begin
			rd_val = baud_divisor;
		end else begin
			rd_val = 8'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'h0;
			pslverr <= 1'h0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pready <= access;
			pslverr <= access & ~hit_any;
			prdata <= access ? {24'h00_0000, rd_val} : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcs <= `SBRG_TCS_RST;
			rcs <= `SBRG_RCS_RST;
			baud_divisor <= `SBRG_DIV_RST;
		end else if (ce) begin
			if (wr_tcs) tcs <= (pwdata[7:0] & `SBRG_TCS_WMASK) | (tcs & ~`SBRG_TCS_WMASK);
			if (wr_rcs) rcs <= (pwdata[7:0] & `SBRG_RCS_WMASK) | (rcs & ~`SBRG_RCS_WMASK);
			if (wr_div) baud_divisor <= pwdata[7:0];
		end
	end

	// ====================================================================
	// control fan-out
	sbrg_ctrl_t next_ctrl;

	assign next_ctrl = '{
		port_en: rcs[`SBRG_RCS_PEN],
		rx9: rcs[`SBRG_RCS_RX9],
		single_rx: rcs[`SBRG_RCS_SINGLE],
		cont_rx: rcs[`SBRG_RCS_CONT],
		clock_source_select: tcs[`SBRG_TCS_CLKSRC],
		tx9: tcs[`SBRG_TCS_TX9],
		tx_en: tcs[`SBRG_TCS_TXEN],
		sync: tcs[`SBRG_TCS_SYNC],
		high_speed_select: tcs[`SBRG_TCS_HSS],
		tx9d: tcs[`SBRG_TCS_TX9D]
	};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '0;
		end else if (ce) begin
			ctrl <= next_ctrl;
		end
	end

	// ====================================================================
	// mode selection
	sbrg_mode_t mode;
	logic [3:0] sub_last;
	logic [3:0] vote_at;

	always_comb begin
		if (!tcs[`SBRG_TCS_SYNC]) begin
			mode = tcs[`SBRG_TCS_HSS] ? SBRG_ASYNC_HIGH : SBRG_ASYNC_LOW;
		end else if (tcs[`SBRG_TCS_CLKSRC]) begin
			mode = SBRG_SYNC_MASTER;
		end else begin
			mode = SBRG_SYNC_SLAVE;
		end
	end

	always_comb begin
		case (mode)
			SBRG_ASYNC_LOW: begin
				sub_last = `SBRG_LOW_LAST;
				vote_at = `SBRG_LOW_VOTE_AT;
			end
			SBRG_ASYNC_HIGH: begin
				sub_last = `SBRG_HIGH_LAST;
				vote_at = `SBRG_HIGH_VOTE_AT;
			end
			default: begin
				sub_last = `SBRG_SYNC_LAST;
				vote_at = `SBRG_SYNC_LAST;
			end
		endcase
	end

	// ====================================================================
	// rate chain: prescale by 4, 8-bit timer, per-mode subdivision
	logic [1:0] pre;
	logic [7:0] timer;
	logic [3:0] sub;
	logic pre_wrap;
	logic timer_wrap;
	logic bit_wrap;

	assign pre_wrap = pre == `SBRG_PRE_LAST;
	assign timer_wrap = pre_wrap & (timer == baud_divisor);
	assign bit_wrap = timer_wrap & (sub == sub_last) & (mode != SBRG_SYNC_SLAVE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre <= 2'h0;
			timer <= 8'h00;
			sub <= 4'h0;
		end else if (ce) begin
			if (restart) begin
				pre <= 2'h0;
				timer <= 8'h00;
				sub <= 4'h0;
			end else begin
				pre <= pre + 2'h1;
				if (timer_wrap) begin
					timer <= 8'h00;
					sub <= (sub == sub_last) ? 4'h0 : sub + 4'h1;
				end else if (pre_wrap) begin
					timer <= timer + 8'h01;
				end
			end
		end
	end

	// restart drops a tick due in the same cycle, since it belongs to the old rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_tick <= 1'h0;
			bit_tick <= 1'h0;
		end else if (ce) begin
			timer_tick <= timer_wrap & ~restart;
			bit_tick <= bit_wrap & ~restart;
		end
	end

	// ====================================================================
	// receive pin synchroniser and majority sampler
	logic rx_meta;
	logic rx_sync;
	logic vote_start;
	logic vote_strobe;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta <= 1'h1;
			rx_sync <= 1'h1;
		end else if (ce) begin
			rx_meta <= receive_data_pin;
			rx_sync <= rx_meta;
		end
	end

	// async samples sit on three timer wraps around mid-bit; sync on three clocks
	assign vote_start = tcs[`SBRG_TCS_SYNC] ? bit_wrap : (timer_wrap & (sub == vote_at));
	assign vote_strobe = tcs[`SBRG_TCS_SYNC] ? 1'h1 : timer_wrap;

	sbrg_vote u_vote (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.start(vote_start & ~restart),
		.strobe(vote_strobe),
		.din(rx_sync),
		.vote(rx_bit),
		.vote_valid(rx_bit_valid)
	);

	// ====================================================================
	// checks
	logic [15:0] gap;
	logic gap_ok;
	logic [15:0] div_plus;

	assign div_plus = {8'h00, baud_divisor} + 16'h0001;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap <= 16'h0000;
			gap_ok <= 1'h0;
		end else if (ce) begin
			if (restart) begin
				gap_ok <= 1'h0;
			end else if (bit_tick) begin
				gap_ok <= 1'h1;
			end
			gap <= bit_tick ? 16'h0001 : gap + 16'h0001;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_div_clear;
		(ce && wr_div) |=> timer == 8'h00 && pre == 2'h0;
	endproperty
	a_div_clear: assert property (p_div_clear) else $error("divisor write kept old count");

	property p_low_rate;
		(ce && bit_tick && gap_ok && mode == SBRG_ASYNC_LOW)
			|-> gap == `SBRG_LOW_RATIO * div_plus;
	endproperty
	a_low_rate: assert property (p_low_rate) else $error("low speed period wrong");

	property p_high_rate;
		(ce && bit_tick && gap_ok && mode == SBRG_ASYNC_HIGH)
			|-> gap == `SBRG_HIGH_RATIO * div_plus;
	endproperty
	a_high_rate: assert property (p_high_rate) else $error("high speed period wrong");

	property p_sync_rate;
		(ce && bit_tick && gap_ok && mode == SBRG_SYNC_MASTER)
			|-> gap == `SBRG_SYNC_RATIO * div_plus;
	endproperty
	a_sync_rate: assert property (p_sync_rate) else $error("sync period wrong");

	property p_timer_range;
		timer <= baud_divisor;
	endproperty
	a_timer_range: assert property (p_timer_range) else $error("timer beyond divisor");

	property p_timer_step;
		(ce && pre_wrap && timer != baud_divisor && !restart)
			|=> timer == $past(timer) + 8'h01 && pre == 2'h0;
	endproperty
	a_timer_step: assert property (p_timer_step) else $error("timer did not advance");

	property p_sync_ignores_speed;
		tcs[`SBRG_TCS_SYNC] |-> sub_last == `SBRG_SYNC_LAST;
	endproperty
	a_sync_ignores_speed: assert property (p_sync_ignores_speed) else $error("speed bit used in sync");

	sequence s_slave_held;
		mode == SBRG_SYNC_SLAVE ##1 mode == SBRG_SYNC_SLAVE;
	endsequence

	property p_slave_quiet;
		s_slave_held |-> !bit_tick;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet) else $error("bit tick as sync slave");

	property p_tick_on_wrap;
		bit_tick |-> timer_tick;
	endproperty
	a_tick_on_wrap: assert property (p_tick_on_wrap) else $error("bit tick without timer wrap");

endmodule : sbrg_top

`default_nettype wire

// File: tb/sbrg_peer.sv
// remote serial peer: drives the receive line with short glitches
`timescale 1ns/1ps
`default_nettype none

module sbrg_peer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic level,
	input wire logic [2:0] phase,
	output logic rx_line
);
	logic [3:0] cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end

	// two bad cycles in sixteen spoil at most one of three samples four cycles apart
	assign rx_line = level ^ (cnt[3:1] == phase);
endmodule : sbrg_peer

`default_nettype wire

// File: tb/test_serial_baud_rate_generator.sv
// self-checking bench for the baud generator and receive sampler
`timescale 1ns/1ps
`default_nettype none
`include "sbrg_regs.svh"

module test_serial_baud_rate_generator
	import sbrg_pkg::*;
;
	localparam logic [11:0] A_RCS = {`SBRG_RCS_IDX, 2'b00};
	localparam logic [11:0] A_TCS = {`SBRG_TCS_IDX, 2'b00};
	localparam logic [11:0] A_DIV = {`SBRG_DIV_IDX, 2'b00};
	localparam int LIM = 20000;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, e;
	logic sre, level, rx_line, timer_tick, bit_tick, rx_bit, rx_bit_valid, rx_chk, exp_rx;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [7:0] cur_t, b;
	logic [2:0] phase;
	sbrg_rx_stat_t rx_status;
	sbrg_ctrl_t ctrl;
	int fails = 0;
	int comparisons = 0;
	int seed = 36866;
	int nv = 0;
	int x;
	logic [7:0] tv [8] = '{8'h04, 8'h04, 8'h00, 8'h00, 8'h90, 8'h94, 8'h10, 8'h04};
	int xv [8] = '{255, -1, 0, -1, 255, -1, -1, 0};

	sbrg_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_status(rx_status), .shift_register_empty(sre),
		.receive_data_pin(rx_line), .ctrl(ctrl), .timer_tick(timer_tick),
		.bit_tick(bit_tick), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid));

	sbrg_peer peer (.pclk(pclk), .presetn(presetn), .level(level), .phase(phase),
		.rx_line(rx_line));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// ====================================================================
	// model and helpers
	function automatic int period(input logic [7:0] t, input int xx);
		if (t[4]) return t[7] ? 4 * (xx + 1) : 0;
		return (t[2] ? 16 : 64) * (xx + 1);
	endfunction : period

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count assumed: a lost answer is left to the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic count_to(input logic bt, output int n);
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while ((bt ? bit_tick : timer_tick) !== 1'b1 && n < LIM);
	endtask : count_to

	task automatic measure(input logic [7:0] t, input int xx);
		int n;
		int p;
		p = period(t, xx);
		// leaving the mode alone lets the first tick prove the divisor write restart
		if (t !== cur_t) apb(1'b1, A_TCS, {24'h5A5A5A, t});
		cur_t = t;
		apb(1'b1, A_DIV, {24'hA5A5A5, xx[7:0]});
		count_to(1'b0, n);
		chk(32'(n), 32'(4 * (xx + 1)));
		count_to(1'b1, n);
		count_to(1'b1, n);
		chk(32'(n), 32'((p == 0) ? LIM : p));
		apb(1'b0, A_TCS, 32'h0);
		chk(r, {24'h0, t & `SBRG_TCS_WMASK | {6'h0, sre, 1'b0}});
		chk(32'({ctrl.sync, ctrl.high_speed_select, ctrl.clock_source_select}), 32'({t[4], t[2], t[7]}));
		apb(1'b0, A_DIV, 32'h0);
		chk(r, {24'h0, xx[7:0]});
	endtask : measure

	task automatic results();
		if (fails == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results

	always @(posedge pclk) begin
		if (rx_bit_valid === 1'b1 && rx_chk === 1'b1) begin
			nv++;
			chk(32'(rx_bit), 32'(exp_rx));
		end
		if (bit_tick === 1'b1) chk(32'(timer_tick), 32'h1);
	end

	// ====================================================================
	// main sequence
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		sre = 1'b1;
		level = 1'b1;
		phase = 3'h0;
		rx_chk = 1'b0;
		exp_rx = 1'b1;
		rx_status = '0;
		cur_t = 8'hFF;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		sre <= 1'($random(seed));
		rx_status <= 3'($random(seed));
		apb(1'b0, A_TCS, 32'h0);
		chk(r, {24'h0, `SBRG_TCS_RST & 8'hFD | {6'h0, sre, 1'b0}});
		apb(1'b0, A_RCS, 32'h0);
		chk(r, {24'h0, `SBRG_RCS_RST | {5'h0, rx_status}});
		apb(1'b0, A_DIV, 32'h0);
		chk(r, {24'h0, `SBRG_DIV_RST});
		apb(1'b0, 12'h004, 32'h0);
		chk(32'(e), 32'h1);
		chk(r, 32'h0);
		b = 8'($random(seed));
		apb(1'b1, A_RCS, {24'hFFFFFF, b});
		apb(1'b0, A_RCS, 32'h0);
		chk(r, {24'h0, b & `SBRG_RCS_WMASK | {5'h0, rx_status}});
		chk(32'({ctrl.port_en, ctrl.rx9, ctrl.single_rx, ctrl.cont_rx}), 32'(b[7:4]));
		for (int i = 0; i < 8; i++) begin
			x = (xv[i] < 0) ? ($random(seed) & 7) : xv[i];
			measure(tv[i], x);
		end
		// still async high, divisor zero: a frozen chain delays the first wrap
		apb(1'b1, A_DIV, 32'h0);
		ce <= 1'b0;
		repeat (9) @(posedge pclk);
		ce <= 1'b1;
		count_to(1'b0, x);
		chk(32'(x), 32'(4 * (0 + 1)));
		// async high, divisor zero: glitchy line must still vote to the driven level
		for (int k = 0; k < 4; k++) begin
			rx_chk <= 1'b0;
			level <= 1'($random(seed));
			phase <= 3'($random(seed));
			repeat (64) @(posedge pclk);
			exp_rx <= level;
			rx_chk <= 1'b1;
			repeat (64) @(posedge pclk);
		end
		rx_chk <= 1'b0;
		chk(32'(nv > 0), 32'h1);
		results();
	end

	// about 53k cycles of tests; 100k cycles means a hang
	initial begin
		#400000;
		fails++;
		results();
	end
endmodule : test_serial_baud_rate_generator

`default_nettype wire
